// >>> rtl/gpmc_pkg.sv
// ============================================================
// Shared constants and types of the pin mode and configuration block.
package gpmc_pkg;

  // Number of pins in the port and pins held by each control register.
  localparam int unsigned PIN_COUNT     = 16;
  localparam int unsigned PINS_PER_REG  = 8;

  // Byte offsets of the registers.
  localparam logic [7:0] OFF_CFG_LOW    = 8'h00;
  localparam logic [7:0] OFF_CFG_HIGH   = 8'h04;
  localparam logic [7:0] OFF_IN_LEVEL   = 8'h08;
  localparam logic [7:0] OFF_OUT_DATA   = 8'h0C;

  // Reset value of both control registers: every pin a floating input.
  localparam logic [31:0] CFG_RESET     = 32'h4444_4444;
  localparam logic [15:0] OUT_RESET     = 16'h0000;

  // Field positions inside one pin nibble.
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned CONF_LSB      = 2;
  localparam int unsigned NIBBLE        = 4;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // Pin mode field encodings.
  typedef enum logic [1:0] {
    GPMC_MODE_INPUT  = 2'h0,
    GPMC_MODE_OUT10M = 2'h1,
    GPMC_MODE_OUT2M  = 2'h2,
    GPMC_MODE_OUT50M = 2'h3
  } gpmc_mode_t;

  // Decoded pad control for one pin.
  typedef struct packed {
    logic       out_en;     // Output driver active.
    logic       open_drain; // Drive only low; release for high.
    logic       alt_func;   // Output taken from the alternate function unit.
    logic       analog;     // Digital input path disabled.
    logic       pull_en;    // Pull resistor enabled.
    logic       pull_up;    // Pull direction, high means pull-up.
    logic [1:0] speed;      // Copy of the mode field as slew grade.
  } gpmc_pad_t;

endpackage

// >>> rtl/gpmc_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// How it works
// R01 - Mode 00 input, 01/10/11 output speeds
// R02 - Input config: analog, floating, pulled, reserved
// R03 - Output config: port/alt, push-pull/open-drain
// R04 - Low register at 0x00 holds pins 0-7
// R05 - High register at 0x04 holds pins 8-15
// R06 - Control registers reset to 0x44444444
// R07 - Fields change only by software writes
// R08 - Input levels readable at 0x08
// R09 - Pulled input direction follows output data bit
module gpmc_top (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [15:0]          pin_level_in,
  output gpmc_pkg::gpmc_pad_t [15:0] pad_ctrl,
  output logic [15:0]               pin_output_data
);

  // ============================================================
  // Register storage
  logic [31:0] cfg_low_q;      // pin_config_low_half.
  logic [31:0] cfg_high_q;     // pin_config_high_half.
  logic [15:0] out_data_q;     // Output data bits, one per pin.
  logic [15:0] lvl_meta_q;     // First synchroniser stage.
  logic [15:0] lvl_q;          // pin_input_level_reg contents.
  logic [7:0]  aw_addr_q;      // Captured write address.
  logic        aw_have_q;      // Write address held.
  logic [31:0] w_data_q;       // Captured write data.
  logic [3:0]  w_strb_q;       // Captured write strobes.
  logic        w_have_q;       // Write data held.
  logic        do_write;       // Both halves present, commit this cycle.
  logic [31:0] rdata_d;        // Read mux output.
  logic        rd_ok;          // Read address mapped.
  logic        wr_ok;          // Write address mapped.

  // ============================================================
  // Write channel handshakes
  // Address and data are taken independently, in either order, and held until
  // the write commits; neither is taken again until the response has been accepted.
  assign s_axi_awready = aresetn && !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = aresetn && !w_have_q && !s_axi_bvalid;
  assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;

  // Address capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  // Data capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  // Writes to the read-only level register or unmapped words get SLVERR.
  always_comb begin
    wr_ok = (aw_addr_q == gpmc_pkg::OFF_CFG_LOW) || (aw_addr_q == gpmc_pkg::OFF_CFG_HIGH) ||
            (aw_addr_q == gpmc_pkg::OFF_OUT_DATA);
  end

  // Write response, one cycle after the commit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpmc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? gpmc_pkg::RESP_OKAY : gpmc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ============================================================
  // Configuration registers
  // Byte strobes are honoured so a byte write touches two pins only.
  // R04 low register decode
  // R05 high register decode
  // R06 reset to floating inputs
  // R07 software-only updates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_low_q  <= gpmc_pkg::CFG_RESET;
      cfg_high_q <= gpmc_pkg::CFG_RESET;
    end else if (do_write) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_q[b] && aw_addr_q == gpmc_pkg::OFF_CFG_LOW) begin
          cfg_low_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
        end
        if (w_strb_q[b] && aw_addr_q == gpmc_pkg::OFF_CFG_HIGH) begin
          cfg_high_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
        end
      end
    end
  end

  // Output data register; its bits also steer pull direction.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data_q <= gpmc_pkg::OUT_RESET;
    end else if (do_write && aw_addr_q == gpmc_pkg::OFF_OUT_DATA) begin
      for (int b = 0; b < 2; b++) begin
        if (w_strb_q[b]) begin
          out_data_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
        end
      end
    end
  end
  assign pin_output_data = out_data_q;

  // ============================================================
  // Input level sampling
  // Pin levels are asynchronous, so two flops come before any reader.
  // R08 sampled level capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_meta_q <= 16'h0000;
      lvl_q      <= 16'h0000;
    end else begin
      lvl_meta_q <= pin_level_in;
      lvl_q      <= lvl_meta_q;
    end
  end

  // ============================================================
  // Read channel
  // Reserved upper bits of the level and data words read as zero.
  always_comb begin
    rd_ok   = 1'b1;
    rdata_d = 32'h0000_0000;
    case (s_axi_araddr)
      gpmc_pkg::OFF_CFG_LOW:  rdata_d = cfg_low_q;
      gpmc_pkg::OFF_CFG_HIGH: rdata_d = cfg_high_q;
      // R08 level register read
      gpmc_pkg::OFF_IN_LEVEL: rdata_d = {16'h0000, lvl_q};
      gpmc_pkg::OFF_OUT_DATA: rdata_d = {16'h0000, out_data_q};
      default:                rd_ok   = 1'b0;
    endcase
  end

  assign s_axi_arready = aresetn && !s_axi_rvalid;

  // Read data registered one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= gpmc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_d;
      s_axi_rresp  <= rd_ok ? gpmc_pkg::RESP_OKAY : gpmc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ============================================================
  // Per-pin decode
  // Pure decode of stored fields; the pad sees changes one cycle after a write.
  for (genvar p = 0; p < 16; p++) begin : g_pin
    logic [3:0] nib;
    logic [1:0] mode;
    logic [1:0] conf;
    assign nib  = (p < 8) ? cfg_low_q[(p % 8)*4 +: 4] : cfg_high_q[(p % 8)*4 +: 4];
    assign mode = nib[gpmc_pkg::MODE_LSB +: 2];
    assign conf = nib[gpmc_pkg::CONF_LSB +: 2];
    always_comb begin
      pad_ctrl[p] = '0;
      pad_ctrl[p].speed = mode;
      // R01 mode decode
      case (gpmc_pkg::gpmc_mode_t'(mode))
        gpmc_pkg::GPMC_MODE_INPUT: begin
          // R02 input config; reserved 11 behaves as floating
          pad_ctrl[p].analog  = (conf == 2'h0);
          pad_ctrl[p].pull_en = (conf == 2'h2);
          // R09 pull direction
          pad_ctrl[p].pull_up = (conf == 2'h2) && out_data_q[p];
        end
        default: begin
          // R03 output config
          pad_ctrl[p].out_en     = 1'b1;
          pad_ctrl[p].open_drain = conf[0];
          pad_ctrl[p].alt_func   = conf[1];
        end
      endcase
    end
  end

  // ============================================================
  // Checks
  // R06 reset value check
  chk_cfg_reset_value: assert property (@(posedge aclk)
    $rose(aresetn) |-> cfg_low_q == gpmc_pkg::CFG_RESET && cfg_high_q == gpmc_pkg::CFG_RESET)
    else $error("control register reset value wrong");

  chk_cfg_sw_only: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    !$past(do_write) |-> $stable(cfg_low_q) && $stable(cfg_high_q))
    else $error("control register changed without a write");

  chk_low_write: assert property (@(posedge aclk) disable iff (!aresetn) // R04
    do_write && aw_addr_q == gpmc_pkg::OFF_CFG_LOW && w_strb_q == 4'hF |=>
      cfg_low_q == $past(w_data_q))
    else $error("low register write lost");

  chk_high_write: assert property (@(posedge aclk) disable iff (!aresetn) // R05
    do_write && aw_addr_q == gpmc_pkg::OFF_CFG_HIGH && w_strb_q == 4'hF |=>
      cfg_high_q == $past(w_data_q))
    else $error("high register write lost");

  chk_mode_output: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    cfg_high_q[29:28] != 2'h0 |-> pad_ctrl[15].out_en && pad_ctrl[15].speed == cfg_high_q[29:28])
    else $error("pin 15 output mode not decoded");

  chk_input_conf: assert property (@(posedge aclk) disable iff (!aresetn) // R02
    cfg_low_q[1:0] == 2'h0 |-> !pad_ctrl[0].out_en && pad_ctrl[0].analog == (cfg_low_q[3:2] == 2'h0))
    else $error("pin 0 input config wrong");

  chk_output_conf: assert property (@(posedge aclk) disable iff (!aresetn) // R03
    cfg_low_q[29:28] != 2'h0 |-> pad_ctrl[7].open_drain == cfg_low_q[30] &&
      pad_ctrl[7].alt_func == cfg_low_q[31])
    else $error("pin 7 output config wrong");

  chk_level_read: assert property (@(posedge aclk) disable iff (!aresetn) // R08
    s_axi_arvalid && s_axi_arready && s_axi_araddr == gpmc_pkg::OFF_IN_LEVEL |=>
      s_axi_rvalid && s_axi_rdata == {16'h0000, $past(lvl_q)})
    else $error("level read wrong");

  chk_pull_dir: assert property (@(posedge aclk) disable iff (!aresetn) // R09
    cfg_high_q[3:0] == 4'h8 |-> pad_ctrl[8].pull_en && pad_ctrl[8].pull_up == out_data_q[8])
    else $error("pin 8 pull direction wrong");

endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ns
// ============================================================
// Self-checking bench of the pin mode block over its AXI4-Lite port.
module testbench;
  logic                       aclk;
  logic                       aresetn;
  logic [7:0]                 awaddr, araddr;
  logic                       awvalid, wvalid, bready, arvalid, rready;
  logic [31:0]                wdata;
  logic [3:0]                 wstrb;
  logic [15:0]                lvl;     // Pin levels driven into the block.
  logic                       awready, wready, bvalid, arready, rvalid;
  logic [1:0]                 bresp, rresp;
  logic [31:0]                rdata;
  gpmc_pkg::gpmc_pad_t [15:0] pad;
  logic [15:0]                odat;
  logic [31:0]                m [4];   // Shadow copy of the words at 0x00, 0x04 and 0x0C.
  logic [1:0]                 bq [$];  // Expected write responses, oldest first.
  logic [33:0]                rq [$];  // Expected read response and data, oldest first.
  logic [31:0]                seed;
  logic [7:0]                 a;
  int                         mismatches;
  int                         checks_done;

  gpmc_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_level_in(lvl), .pad_ctrl(pad), .pin_output_data(odat)
  );

  // 250 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Pseudo-random source; a fixed start keeps every run identical.
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(logic [33:0] got, logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ============================================================
  // Bus tasks; each notes its expected answer before it starts.
  task automatic wr(logic [7:0] ad, logic [31:0] d, logic [3:0] s);
    logic ok;
    ok = (ad == 8'h00) || (ad == 8'h04) || (ad == 8'h0C);
    bq.push_back(ok ? gpmc_pkg::RESP_OKAY : gpmc_pkg::RESP_SLVERR);
    for (int b = 0; b < 4; b++) begin
      if (ok && s[b]) m[ad[3:2]][8*b +: 8] = d[8*b +: 8];
    end
    // Only the low half of the output data word exists.
    m[3][31:16] = 16'h0000;
    awaddr  <= ad;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    // One idle edge keeps the next call from reassigning bready in this step.
    @(posedge aclk);
  endtask

  task automatic rd(logic [7:0] ad);
    case (ad)
      8'h00, 8'h04, 8'h0C: rq.push_back({gpmc_pkg::RESP_OKAY, m[ad[3:2]]});
      8'h08: rq.push_back({gpmc_pkg::RESP_OKAY, 16'h0000, lvl});
      default: rq.push_back({gpmc_pkg::RESP_SLVERR, 32'h0000_0000});
    endcase
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    // One idle edge keeps the next call from reassigning rready in this step.
    @(posedge aclk);
  endtask

  // Expected pad decode per pin; pull direction only matters when pulled.
  task automatic pads();
    gpmc_pkg::gpmc_pad_t e, g;
    logic [3:0] n;
    @(posedge aclk);
    for (int p = 0; p < 16; p++) begin
      n = m[p / 8][4 * (p % 8) +: 4];
      e = '0;
      e.speed = n[1:0];
      if (n[1:0] != 2'h0) begin
        e.out_en = 1'b1;
        e.open_drain = n[2];
        e.alt_func = n[3];
      end else begin
        e.analog = (n[3:2] == 2'h0);
        e.pull_en = (n[3:2] == 2'h2);
        e.pull_up = m[3][p];
      end
      g = pad[p];
      if (!e.pull_en) g.pull_up = e.pull_up;
      chk({25'h0, g}, {25'h0, e});
    end
    chk({18'h0, odat}, {18'h0, m[3][15:0]});
  endtask

  // ============================================================
  // Watcher: compares each response with the oldest note.
  always @(posedge aclk) begin
    if (bvalid && bready) chk({bresp, 32'h0}, {bq.pop_front(), 32'h0});
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
  end

  // Watchdog cuts a hang short.
  initial begin
    #100000;
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  // ============================================================
  // Main sequence.
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    lvl = 16'h0000;
    seed = 32'hABA3;
    m[0] = gpmc_pkg::CFG_RESET;
    m[1] = gpmc_pkg::CFG_RESET;
    m[2] = 32'h0000_0000;
    m[3] = 32'h0000_0000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00);
    rd(8'h04);
    rd(8'h0C);
    pads();
    wr(8'h00, 32'h7654_3210, 4'hF);
    wr(8'h04, 32'hFEDC_BA98, 4'hF);
    pads();
    wr(8'h0C, 32'h0000_A5C3, 4'hF);
    wr(8'h00, 32'h8888_8888, 4'hF);
    wr(8'h04, 32'h8888_8888, 4'hF);
    pads();
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      lvl <= seed[31:16];
      a = {4'h0, seed[5:4], 2'h0};
      wr(a, lfsr(seed), seed[3:0]);
      rd(a);
      pads();
    end
    wr(8'h10, 32'h1234_5678, 4'hF);
    rd(8'h10);
    rd(8'h00);
    rd(8'h08);
    // A mid-run reset must bring every pin back to a floating input.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    m[0] = gpmc_pkg::CFG_RESET;
    m[1] = gpmc_pkg::CFG_RESET;
    m[3] = 32'h0000_0000;
    rd(8'h00);
    rd(8'h04);
    pads();
    results();
  end
endmodule
